/* File: core/drm_core.sv */
// Loop core: reference monitor, phase loop, oscillator and divider
`timescale 1ns/1ps
module drm_core
  import drm_pkg::*;
(
  input wire logic ref_clk, // 125 MHz clock
  input wire logic sys_rst, // Synchronous reset
  input wire logic [3:0] avs_address, // Byte address
  input wire logic avs_read, // Read request
  input wire logic avs_write, // Write request
  input wire logic [3:0] avs_byteenable, // Write lanes
  input wire logic [31:0] avs_writedata, // Write data
  output logic [31:0] avs_readdata, // Read data
  output logic avs_waitrequest, // Stall
  input wire logic ext_ref, // External reference
  input wire logic frame_ref, // Internal 8 kHz reference
  output logic reference_fail_flag, // Reference invalid
  output logic switching_timing_clock, // Oscillator output
  output logic divided_2048k_clock, // 2.048 MHz
  output logic divided_1544k_clock, // 1.544 MHz
  output logic frame_pulse_n // 8 kHz frame, low
);

  drm_state_t s;
  drm_state_t next_s;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    logic ref_now;
    logic rise;
    logic fall;
    logic fast;
    logic locked;
    logic bad;
    logic wbad;
    drm_freq_t eff;
    logic [31:0] cur;
    logic [31:0] wr;
    logic [31:0] ph;
    logic [31:0] p193;
    logic [31:0] fbp;
    logic [15:0] lo;
    logic [15:0] hi;
    logic [15:0] wlo;
    logic [15:0] whi;
    logic signed [39:0] skew_u;
    logic signed [39:0] err;
    logic signed [39:0] lim;
    logic signed [39:0] fo;
    logic signed [47:0] step;
    int shift_sh;
    int lp_sh;
    ref_now = 1'b0;
    rise = 1'b0;
    fall = 1'b0;
    fast = 1'b0;
    locked = 1'b0;
    bad = 1'b0;
    wbad = 1'b0;
    eff = DRM_F8K;
    cur = 32'h00000000;
    wr = 32'h00000000;
    ph = 32'h00000000;
    p193 = 32'h00000000;
    fbp = 32'h00000000;
    lo = LO8K;
    hi = HI8K;
    wlo = WLO2048;
    whi = WHI2048;
    skew_u = SKEW_U8K;
    err = '0;
    lim = '0;
    fo = '0;
    step = '0;
    shift_sh = SHIFT_SH_8K;
    lp_sh = LP_SH_8K;
    next_s = s;

    // Register view for reads and byte merge
    case (avs_address)
      OFS_CTRL: cur = 32'(s.bypass) << BYPASS_BIT;
      OFS_MODE: cur = (32'(s.freerun) << FREERUN_BIT)
                    | (32'(s.freq) << FREQ_LSB)
                    | (32'(s.refsel) << REFSEL_BIT);
      OFS_ADJ: cur = (32'(s.phase_shift_field) << SHIFT_LSB)
                   | (32'(s.reference_skew_field) << SKEW_LSB);
      OFS_STAT: cur = 32'(s.fail) << FAIL_BIT;
      default: cur = 32'h00000000;
    endcase
    for (int i = 0; i < 4; i++) begin
      wr[8*i +: 8] = avs_byteenable[i] ? avs_writedata[8*i +: 8]
                                       : cur[8*i +: 8];
    end

    // Two-edge handshake: latch read data as the stall is released, then raise it again
    if (s.bus_wait) begin
      if (avs_read || avs_write) begin
        next_s.bus_wait = 1'b0;
        next_s.rdata = avs_read ? cur : 32'h00000000;
      end
    end else begin
      next_s.bus_wait = 1'b1;
      if (avs_write) begin
        case (avs_address)
          OFS_CTRL: next_s.bypass = wr[BYPASS_BIT];
          OFS_MODE: begin
            next_s.freerun = wr[FREERUN_BIT];
            next_s.freq = wr[FREQ_LSB +: 2];
            next_s.refsel = wr[REFSEL_BIT];
          end
          OFS_ADJ: begin
            next_s.phase_shift_field = wr[SHIFT_LSB +: 7];
            next_s.reference_skew_field = wr[SKEW_LSB +: 3];
          end
          default: ;
        endcase
      end
    end

    // Source and rate selection
    ref_now = s.refsel ? frame_ref : ext_ref;
    // Internal frame reference is always 8 kHz, whatever the field
    eff = s.refsel ? DRM_F8K : drm_freq_t'(s.freq);
    rise = ref_now && !s.ref_q;
    fall = !ref_now && s.ref_q;
    case (eff)
      DRM_F1544: begin
        lo = LO1544;
        hi = HI1544;
        wlo = WLO1544;
        whi = WHI1544;
        skew_u = SKEW_U1544;
        shift_sh = SHIFT_SH_FAST;
        lp_sh = LP_SH_1544;
        fast = 1'b1;
      end
      DRM_F2048: begin
        lo = LO2048;
        hi = HI2048;
        skew_u = SKEW_U2048;
        shift_sh = SHIFT_SH_FAST;
        lp_sh = LP_SH_2048;
        fast = 1'b1;
      end
      default: begin
        lo = LO8K;
        hi = HI8K;
        skew_u = SKEW_U8K;
        shift_sh = SHIFT_SH_8K;
        lp_sh = LP_SH_8K;
      end
    endcase

    // ----------------------------------------
    // Reference monitor
    // ----------------------------------------
    next_s.ref_q = ref_now;
    next_s.lvl_cnt = s.lvl_cnt + {15'h0000, s.lvl_cnt != 16'hFFFF};
    next_s.per_cnt = s.per_cnt + {15'h0000, s.per_cnt != 16'hFFFF};
    next_s.win_cnt = s.win_cnt + {15'h0000, s.win_cnt != 16'hFFFF};
    if (rise || fall) begin
      next_s.lvl_cnt = 16'h0001;
    end
    // Checks wait for the first rising edge so reset is not a failure
    if (s.armed) begin
      if ((rise || fall) && s.lvl_cnt < MIN_LEVEL_CYC) begin
        bad = 1'b1;
      end
      if ((rise && s.per_cnt < lo) || s.per_cnt > hi) begin
        bad = 1'b1;
      end
      if (fast && s.win_cnt > whi) begin
        wbad = 1'b1;
      end
    end
    if (rise) begin
      next_s.armed = 1'b1;
      next_s.per_cnt = 16'h0001;
      next_s.per_bad = 1'b0;
      next_s.win_n = s.win_n + 7'h01;
      if (!s.armed || s.win_n == WIN_PERIODS - 7'h01) begin
        next_s.win_n = 7'h00;
        next_s.win_cnt = 16'h0001;
        if (s.armed && fast && s.win_cnt < wlo) begin
          wbad = 1'b1;
        end
        next_s.win_bad = wbad;
      end
    end else begin
      next_s.per_bad = s.per_bad || bad;
    end
    if (wbad) begin
      next_s.win_bad = 1'b1;
    end
    // Violation wins over a clearing edge in the same cycle
    if (bad || wbad) begin
      next_s.fail = 1'b1;
    end else if (rise && s.armed && !s.per_bad
                 && !(fast && s.win_bad)) begin
      next_s.fail = 1'b0;
    end

    // ----------------------------------------
    // Oscillator and divider
    // ----------------------------------------
    locked = !s.bypass && !s.freerun;
    // Bypass has no analog path here, so it also runs at center
    step = 48'(DCO_CENTER);
    if (locked) begin
      step = step + 48'(s.foff);
    end
    next_s.acc = s.acc + 48'(step);
    ph = s.acc[47:16];
    p193 = ph * 32'h000000C1;
    next_s.tclk = ph[20];
    next_s.div2048 = ph[23];
    next_s.div1544 = p193[31];
    next_s.frame_n = !(ph < FRAME_THR);

    // Feedback phase seen at the reference edge
    case (eff)
      DRM_F1544: fbp = p193;
      DRM_F2048: fbp = {ph[23:0], 8'h00};
      default: fbp = ph;
    endcase
    err = 40'($signed(fbp[31:8]));
    err = err + (40'($signed(s.phase_shift_field)) <<< shift_sh);
    err = err + $signed(40'(s.reference_skew_field)) * skew_u;
    // Clamp keeps a phase jump from slewing the output too fast
    if (err > ERR_LIM) begin
      lim = ERR_LIM;
    end else if (err < -ERR_LIM) begin
      lim = -ERR_LIM;
    end else begin
      lim = err;
    end

    // ----------------------------------------
    // Loop filter
    // ----------------------------------------
    fo = -(s.lp >>> LOOP_GAIN_SH);
    if (fo > SLOPE_LIM) begin
      fo = SLOPE_LIM;
    end else if (fo < -SLOPE_LIM) begin
      fo = -SLOPE_LIM;
    end
    if (!locked) begin
      next_s.integ = '0;
      next_s.lp = '0;
      next_s.foff = '0;
    end else if (rise) begin
      // Integrator gives zero static error at the adder output
      next_s.integ = s.integ + lim;
      next_s.lp = s.lp + ((s.integ - s.lp) >>> lp_sh);
      next_s.foff = 36'(fo);
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      s <= STATE_RST;
    end else begin
      s <= next_s;
    end
  end

  // Outputs straight from state
  assign avs_readdata = s.rdata;
  assign avs_waitrequest = s.bus_wait;
  assign reference_fail_flag = s.fail;
  assign switching_timing_clock = s.tclk;
  assign divided_2048k_clock = s.div2048;
  assign divided_1544k_clock = s.div1544;
  assign frame_pulse_n = s.frame_n;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  logic h_rise;
  logic h_edge;
  logic h_2048;
  logic h_8k;
  logic h_1544;
  assign h_rise = (s.refsel ? frame_ref : ext_ref) && !s.ref_q;
  assign h_edge = (s.refsel ? frame_ref : ext_ref) != s.ref_q;
  assign h_2048 = !s.refsel && s.freq == DRM_F2048;
  assign h_8k = s.refsel || s.freq == DRM_F8K || s.freq == DRM_FRSV;
  assign h_1544 = !s.refsel && s.freq == DRM_F1544;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  chk_fail_status: assert property (
    !avs_waitrequest && avs_read && avs_address == OFS_STAT
    |-> avs_readdata[FAIL_BIT] == $past(reference_fail_flag))
    else $error("status read does not show fail flag");
  chk_short_level: assert property (
    s.armed && h_edge && s.lvl_cnt < MIN_LEVEL_CYC
    |=> reference_fail_flag)
    else $error("short level not flagged");
  chk_fast_period: assert property (
    s.armed && h_2048 && s.per_cnt > HI2048 |=> reference_fail_flag)
    else $error("long fast period not flagged");
  chk_frame_period: assert property (
    s.armed && h_8k && h_rise && (s.per_cnt < LO8K || s.per_cnt > HI8K)
    |=> reference_fail_flag)
    else $error("8 kHz period error not flagged");
  chk_window_span: assert property (
    s.armed && h_2048 && s.win_cnt > WHI2048 |=> reference_fail_flag)
    else $error("64 period window not flagged");
  chk_free_center: assert property (
    s.freerun |=> s.acc == $past(s.acc) + 48'(DCO_CENTER))
    else $error("free run not at center step");
  chk_slope_cap: assert property (
    $signed(40'(s.foff)) <= SLOPE_LIM && $signed(40'(s.foff)) >= -SLOPE_LIM)
    else $error("frequency offset beyond slope limit");
  chk_frame_width: assert property (
    $fell(frame_pulse_n) |-> !frame_pulse_n [*8])
    else $error("frame pulse too short");
  chk_bypass_idle: assert property (
    s.bypass |=> s.foff == '0 && s.integ == '0)
    else $error("loop active in bypass");
  chk_fail_release: assert property (
    $fell(reference_fail_flag) |-> $past(h_rise))
    else $error("fail cleared away from a reference edge");
  chk_bus_answer: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus request not answered next cycle");
  // Stall drops for exactly one cycle; a request still held after that cycle is taken again once the stall is back high
  chk_wait_single: assert property (
    !avs_waitrequest |=> avs_waitrequest)
    else $error("wait request low for more than one cycle");
  // Read data only move when a request is latched
  chk_rdata_hold: assert property (
    !(avs_waitrequest && (avs_read || avs_write)) |=> $stable(avs_readdata))
    else $error("read data changed without a request");

  // Rate specific limits not covered by the 2.048 MHz checks above
  chk_fast_short: assert property (
    s.armed && h_2048 && h_rise && s.per_cnt < LO2048
    |=> reference_fail_flag)
    else $error("short fast period not flagged");
  chk_slow_period: assert property (
    s.armed && h_1544 && s.per_cnt > HI1544 |=> reference_fail_flag)
    else $error("long 1.544 MHz period not flagged");
  chk_slow_window: assert property (
    s.armed && h_1544 && s.win_cnt > WHI1544 |=> reference_fail_flag)
    else $error("1.544 MHz window overrun not flagged");

  // Locked loop and free run: a stale offset or an unclamped error would slew too fast
  chk_locked_step: assert property (
    !s.bypass && !s.freerun
    |=> s.acc == $past(s.acc) + 48'(DCO_CENTER) + 48'($past(s.foff)))
    else $error("locked step not center plus offset");
  chk_error_clamp: assert property (
    !s.bypass && !s.freerun
    |=> s.integ - $past(s.integ) <= ERR_LIM
        && s.integ - $past(s.integ) >= -ERR_LIM)
    else $error("integrator step beyond error clamp");
  chk_free_idle: assert property (
    s.freerun |=> s.foff == '0)
    else $error("filter offset active in free run");

  cov_fail_set: cover property ($rose(reference_fail_flag));
  cov_fail_clear: cover property ($fell(reference_fail_flag));
  cov_write_done: cover property (avs_write && !avs_waitrequest);
  cov_locked_rise: cover property (!s.bypass && !s.freerun && h_rise);
  cov_window_bad: cover property (s.armed && h_2048 && s.win_cnt > WHI2048);
endmodule

/* File: core/drm_pkg.sv */
// Register map, timing constants and state types of the loop core
package drm_pkg;
  localparam longint CLK_PS = 8000;

  // Register byte offsets
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_MODE = 4'h4;
  localparam logic [3:0] OFS_ADJ = 4'h8;
  localparam logic [3:0] OFS_STAT = 4'hC;

  // Field positions
  localparam int BYPASS_BIT = 14;
  localparam int FREERUN_BIT = 0;
  localparam int FREQ_LSB = 1;
  localparam int REFSEL_BIT = 3;
  localparam int SHIFT_LSB = 0;
  localparam int SKEW_LSB = 7;
  localparam int FAIL_BIT = 0;

  typedef enum logic [1:0] {DRM_F8K, DRM_F1544, DRM_F2048, DRM_FRSV} drm_freq_t;

  // Least time rounds up, longest rounds down
  function automatic logic [15:0] cyc_lo(longint ps, longint n, longint d);
    return 16'((ps * n + d * CLK_PS - 1) / (d * CLK_PS));
  endfunction
  function automatic logic [15:0] cyc_hi(longint ps, longint n, longint d);
    return 16'((ps * n) / (d * CLK_PS));
  endfunction

  localparam longint MIN_LEVEL_PS = 90000;
  localparam logic [15:0] MIN_LEVEL_CYC = cyc_lo(MIN_LEVEL_PS, 1, 1);
  localparam longint P2048_PS = 488281;
  localparam longint P1544_PS = 647668;
  localparam longint P8K_PS = 125000000;
  localparam logic [15:0] LO2048 = cyc_lo(P2048_PS, 3, 4);
  localparam logic [15:0] HI2048 = cyc_hi(P2048_PS, 5, 4);
  localparam logic [15:0] LO1544 = cyc_lo(P1544_PS, 3, 4);
  localparam logic [15:0] HI1544 = cyc_hi(P1544_PS, 5, 4);
  localparam logic [15:0] LO8K = cyc_lo(P8K_PS, 31, 32);
  localparam logic [15:0] HI8K = cyc_hi(P8K_PS, 33, 32);
  localparam logic [6:0] WIN_PERIODS = 7'h40;
  localparam logic [15:0] WLO2048 = cyc_lo(P2048_PS, 62, 1);
  localparam logic [15:0] WHI2048 = cyc_hi(P2048_PS, 66, 1);
  localparam logic [15:0] WLO1544 = cyc_lo(P1544_PS, 62, 1);
  localparam logic [15:0] WHI1544 = cyc_hi(P1544_PS, 66, 1);

  // Oscillator: 48 bit accumulator wraps once per 125 us frame
  localparam logic [35:0] DCO_CENTER =
    36'((longint'(1) << 48) / (P8K_PS / CLK_PS));
  localparam longint SLOPE_PPM = 56;
  localparam logic signed [39:0] SLOPE_LIM =
    40'(longint'(DCO_CENTER) * SLOPE_PPM / 1000000);
  localparam longint FRAME_LOW_PS = 122000;
  localparam logic [31:0] FRAME_THR =
    32'(((longint'(1) << 32) * FRAME_LOW_PS) / P8K_PS);

  // Error scaling, 2^24 units per feedback period
  localparam logic signed [39:0] ERR_LIM = 40'sh0000040000;
  localparam int SHIFT_SH_FAST = 19;
  localparam int SHIFT_SH_8K = 11;
  localparam logic signed [39:0] SKEW_U2048 = 40'sh000000FF01;
  localparam logic signed [39:0] SKEW_U1544 = 40'sh000000C040;
  localparam logic signed [39:0] SKEW_U8K = 40'sh00000000FF;
  localparam int LP_SH_8K = 10;
  localparam int LP_SH_1544 = 17;
  localparam int LP_SH_2048 = 18;
  localparam int LOOP_GAIN_SH = 4;

  typedef struct packed {
    logic bus_wait;
    logic [31:0] rdata;
    logic bypass;
    logic freerun;
    logic [1:0] freq;
    logic refsel;
    logic [6:0] phase_shift_field;
    logic [2:0] reference_skew_field;
    logic ref_q;
    logic armed;
    logic [15:0] lvl_cnt;
    logic [15:0] per_cnt;
    logic [15:0] win_cnt;
    logic [6:0] win_n;
    logic per_bad;
    logic win_bad;
    logic fail;
    logic [47:0] acc;
    logic signed [39:0] integ;
    logic signed [39:0] lp;
    logic signed [35:0] foff;
    logic tclk;
    logic div2048;
    logic div1544;
    logic frame_n;
  } drm_state_t;

  // Reset: locked mode, external 8 kHz reference, zero adjust
  localparam drm_state_t STATE_RST =
    '{bus_wait: 1'b1, frame_n: 1'b1, default: '0};
endpackage

/* File: test/drm_core_tb_top.sv */
// Self-checking bench for the loop core and its reference monitor
`timescale 1ns/1ps
module drm_core_tb_top;
  import drm_pkg::*;
  // ------------------------------------------------------------
  // Signals, clock and instances
  // ------------------------------------------------------------
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [3:0] avs_byteenable = 4'h0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic ext_ref;
  logic frame_ref;
  logic reference_fail_flag;
  logic switching_timing_clock;
  logic divided_2048k_clock;
  logic divided_1544k_clock;
  logic frame_pulse_n;
  int n_errors = 0;
  int check_count = 0;
  logic [31:0] exp_q[$];
  logic [31:0] rng = 32'd91400;
  int tbl_lo[6] = '{16, 15, 31, 46, 47, 31};
  bit tbl_e[6] = '{0, 1, 0, 0, 1, 0};

  // 125 MHz bench clock
  always #4 ref_clk = ~ref_clk;

  drm_core DUT (.ref_clk, .sys_rst, .avs_address, .avs_read, .avs_write,
    .avs_byteenable, .avs_writedata, .avs_readdata, .avs_waitrequest,
    .ext_ref, .frame_ref, .reference_fail_flag, .switching_timing_clock,
    .divided_2048k_clock, .divided_1544k_clock, .frame_pulse_n);

  drm_ref_model REF (.ref_clk, .ext_ref, .frame_ref);

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic int rnd(input int span);
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return int'(rng % 32'(span));
  endfunction

  task automatic close_out();
    $display("Checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic tmo(input string nm);
    n_errors++;
    $display("Error %s expected done seen timeout", nm);
    close_out();
  endtask

  task automatic chk_eq(input string nm, input logic [31:0] e,
                        input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_rng(input string nm, input int lo, input int hi,
                         input int g);
    check_count++;
    if (g < lo || g > hi) begin
      n_errors++;
      $display("Error %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask

  // Request held until waitrequest is sampled low; no fixed latency
  task automatic bus(input bit wr, input logic [3:0] a,
                     input logic [31:0] d, input logic [3:0] be);
    int n;
    n = 0;
    @(posedge ref_clk);
    avs_address <= a;
    avs_read <= !wr;
    avs_write <= wr;
    avs_writedata <= d;
    avs_byteenable <= be;
    do begin
      @(posedge ref_clk);
      n++;
      if (n > 50) tmo("bus");
    end while (avs_waitrequest !== 1'b0);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0, 4'h0);
  endtask

  // Status read a few cycles after the closing rise, high phase runs on
  task automatic ep(input int lo, input int hi, input bit intl,
                    input bit e);
    fork
      REF.period(lo, hi, intl);
      begin
        repeat (lo + 3) @(posedge ref_clk);
        rd(OFS_STAT, {31'h0, e});
        chk_eq("fail_pin", {31'h0, e}, {31'h0, reference_fail_flag});
      end
    join
  endtask

  task automatic run(input int n, input int lo, input int span,
                     input int hi, input bit intl, input bit e);
    repeat (n - 1) REF.period(lo + rnd(span), hi, intl);
    ep(lo + rnd(span), hi, intl, e);
  endtask

  function automatic logic sel(input int w);
    case (w)
      0: return divided_2048k_clock;
      1: return divided_1544k_clock;
      3: return switching_timing_clock;
      default: return !frame_pulse_n;
    endcase
  endfunction

  task automatic tick(inout int n);
    @(posedge ref_clk);
    n++;
    if (n > 40000) tmo("divider");
  endtask

  // Active time and rise-to-rise period of one divider output
  task automatic meas(input int w, output int hi, output int per);
    int n;
    n = 0;
    hi = 0;
    while (sel(w) !== 1'b0) tick(n);
    while (sel(w) !== 1'b1) tick(n);
    while (sel(w) === 1'b1) tick(hi);
    per = hi;
    while (sel(w) !== 1'b1) tick(per);
  endtask

  // ------------------------------------------------------------
  // Read scoreboard: oldest note against each completed read
  // ------------------------------------------------------------
  always @(posedge ref_clk) begin
    if (avs_read && avs_waitrequest === 1'b0) begin
      chk_eq("readdata", exp_q.pop_front(), avs_readdata);
    end
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    int h;
    int p;
    logic [31:0] d;
    repeat (12) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    // Mapped and unmapped words all read zero after reset
    for (int i = 0; i < 16; i += 2) rd(4'(i), 32'h0);
    bus(1'b1, OFS_CTRL, 32'hFFFFFFFF, 4'h1);
    rd(OFS_CTRL, 32'h0);
    bus(1'b1, OFS_CTRL, 32'hFFFFFFFF, 4'hF);
    rd(OFS_CTRL, 32'h00004000);
    bus(1'b1, OFS_CTRL, 32'h0, 4'hF);
    d = 32'(rnd(32'h7FFFFFFF));
    bus(1'b1, OFS_ADJ, d, 4'hF);
    rd(OFS_ADJ, d & 32'h000003FF);
    bus(1'b1, OFS_STAT, 32'hFFFFFFFF, 4'hF);
    rd(OFS_STAT, 32'h0);
    bus(1'b1, OFS_MODE, 32'hFFFFFFFF, 4'hF);
    rd(OFS_MODE, 32'h0000000F);
    // Free-run at 2.048 MHz; divider watched while the monitor is driven
    bus(1'b1, OFS_MODE, 32'h5, 4'hF);
    fork
      begin
        meas(0, h, p);
        chk_rng("div2048_period", 61, 62, p);
        chk_rng("div2048_high", 30, 31, h);
        meas(1, h, p);
        chk_rng("div1544_period", 80, 81, p);
        chk_rng("div1544_high", 40, 41, h);
        meas(3, h, p);
        chk_rng("tclk_period", 7, 8, p);
        chk_rng("tclk_high", 3, 4, h);
        meas(2, h, p);
        chk_rng("frame_period", 15625, 15626, p);
        chk_rng("frame_low", 15, 16, h);
      end
      begin
        REF.period(40, 30, 1'b0);
        run(70, 30, 3, 30, 1'b0, 1'b0);
        foreach (tbl_lo[i]) ep(tbl_lo[i], 30, 1'b0, tbl_e[i]);
        REF.period(31, 11, 1'b0);
        ep(50, 30, 1'b0, 1'b1);
        run(70, 30, 3, 30, 1'b0, 1'b0);
        REF.period(31, 50, 1'b0);
        ep(11, 30, 1'b0, 1'b1);
        run(140, 30, 3, 30, 1'b0, 1'b0);
        // Long enough that one whole 64-period window is all slow
        run(130, 34, 1, 30, 1'b0, 1'b1);
        run(140, 30, 3, 30, 1'b0, 1'b0);
        bus(1'b1, OFS_MODE, 32'h3, 4'hF);
        run(140, 40, 3, 40, 1'b0, 1'b0);
        run(70, 37, 1, 40, 1'b0, 1'b1);
        run(140, 40, 3, 40, 1'b0, 1'b0);
      end
    join
    // Internal source forces the 8 kHz checks over the rate field, locked
    bus(1'b1, OFS_MODE, 32'hC, 4'hF);
    REF.period(100, 8000, 1'b1);
    ep(7300 + rnd(600), 8000, 1'b1, 1'b0);
    ep(7100, 100, 1'b1, 1'b1);
    close_out();
  end
endmodule

/* File: test/drm_ref_model.sv */
// Reference source model: drives the external and internal references
`timescale 1ns/1ps
module drm_ref_model (
  input wire logic ref_clk, // Bench clock
  output logic ext_ref, // External reference line
  output logic frame_ref // Internal 8 kHz reference line
);
  // Both lines rest low until a period is requested
  initial begin
    ext_ref = 1'b0;
    frame_ref = 1'b0;
  end

  // Low phase then high phase; the rise closes the previous period
  task automatic period(input int lo, input int hi, input bit intl);
    if (intl) frame_ref <= 1'b0;
    else ext_ref <= 1'b0;
    repeat (lo) @(posedge ref_clk);
    if (intl) frame_ref <= 1'b1;
    else ext_ref <= 1'b1;
    repeat (hi) @(posedge ref_clk);
  endtask
endmodule
